/* File: iolm_pkg.sv */
package iolm_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned IOLM_AW    = 6;
  localparam int unsigned IOLM_DW    = 32;
  localparam int unsigned IOLM_LINES = 32;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_PULLUP_OFF          = 6'h00;
  localparam logic [5:0] OFS_PULLUP_ON           = 6'h04;
  localparam logic [5:0] OFS_PULLUP_STATE        = 6'h08;
  localparam logic [5:0] OFS_PERIPH_A_ASSIGN     = 6'h0C;
  localparam logic [5:0] OFS_PERIPH_B_ASSIGN     = 6'h10;
  localparam logic [5:0] OFS_PERIPH_CHOICE_STATE = 6'h14;
  localparam logic [5:0] OFS_OUT_WRITE_UNMASK    = 6'h18;
  localparam logic [5:0] OFS_OUT_WRITE_MASK      = 6'h1C;
  localparam logic [5:0] OFS_OUT_WRITE_MSTATE    = 6'h20;
  localparam logic [5:0] OFS_OUTPUT_LEVEL_DATA   = 6'h24;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_PULLUP_ON   = 32'hFFFFFFFF;
  localparam logic [31:0] RST_PERIPH_B    = 32'h00000000;
  localparam logic [31:0] RST_WRITE_UNMSK = 32'h00000000;
  localparam logic [31:0] RST_LEVEL_DATA  = 32'h00000000;
  localparam logic [31:0] IOLM_ZERO       = 32'h00000000;

  // ----------------------------------------------------------------
  // bus request and answer carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } iolm_req_s;

  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } iolm_rsp_s;

  // slave states
  typedef enum logic [0:0] {
    IOLM_IDLE,
    IOLM_DONE
  } iolm_state_e;

endpackage

/* File: iolm_setclr.sv */
module iolm_setclr
  import iolm_pkg::*;
#(
  parameter int unsigned        W     = 32,
  parameter logic [W-1:0]       RSTV  = '0
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // set and clear strobes, one bit per line
  input  wire logic [W-1:0] set_bits,
  input  wire logic [W-1:0] clr_bits,
  // held state
  output logic      [W-1:0] state_r
);

  // ones set, ones clear, zeros keep; set wins if both
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= RSTV;
    end else begin
      state_r <= (state_r & ~clr_bits) | set_bits;
    end
  end

endmodule

/* File: iolm_out_level.sv */
module iolm_out_level
  import iolm_pkg::*;
#(
  parameter int unsigned W = 32
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // write of the level register
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_data,
  input  wire logic [W-1:0] wr_allow,
  // driven levels
  output logic      [W-1:0] level_r
);

  // only unmasked lines take the written level
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      level_r <= RST_LEVEL_DATA[W-1:0];
    end else if (wr_en) begin
      level_r <= (level_r & ~wr_allow) | (wr_data & wr_allow);
    end
  end

endmodule

/* File: iolm_top.sv */
// Operation
// - pullup_on write one enables line pull-up
// - pullup_state reads zero when pull-up on
// - periph_a_assign one hands line to A
// - periph_b_assign one hands line to B
// - periph_choice_state: zero A, one B
// - out_write_unmask one lets level writes through
// - out_write_mask one blocks level writes
// - out_write_mask_state one means writes follow
// - pullup_off write one disables line pull-up
// - level bit one drives high, zero low
module iolm_top
  import iolm_pkg::*;
#(
  parameter int unsigned LINES = IOLM_LINES
) (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // avalon-mm slave
  input  wire logic [5:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [3:0]        avs_byteenable,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // line controls
  output logic      [LINES-1:0]  pullup_en,
  output logic      [LINES-1:0]  periph_b_sel,
  output logic      [LINES-1:0]  line_level
);

  // ----------------------------------------------------------------
  // request capture
  // ----------------------------------------------------------------
  iolm_req_s   req;
  iolm_rsp_s   rsp;
  iolm_state_e state_r;
  logic [31:0] rdata_r;
  logic [31:0] be_mask;
  logic [31:0] wmask;
  logic        wr_go;
  logic        rd_go;

  assign req.read       = avs_read;
  assign req.write      = avs_write;
  assign req.address    = avs_address;
  assign req.byteenable = avs_byteenable;
  assign req.writedata  = avs_writedata;

  // byte enables widen into a bit mask
  assign be_mask = {{8{req.byteenable[3]}}, {8{req.byteenable[2]}},
                    {8{req.byteenable[1]}}, {8{req.byteenable[0]}}};
  assign wmask   = req.writedata & be_mask;

  // one wait cycle; a write acts only in the cycle where waitrequest is low
  assign wr_go = req.write && (state_r == IOLM_DONE);
  assign rd_go = req.read && (state_r == IOLM_IDLE);

  // ----------------------------------------------------------------
  // slave state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= IOLM_IDLE;
    end else begin
      case (state_r)
        IOLM_IDLE: begin
          if (req.read || req.write) begin
            state_r <= IOLM_DONE;
          end
        end
        IOLM_DONE: state_r <= IOLM_IDLE;
        default:   state_r <= IOLM_IDLE;
      endcase
    end
  end

  assign rsp.waitrequest = (req.read || req.write) && (state_r == IOLM_IDLE);
  assign rsp.readdata    = rdata_r;
  assign avs_waitrequest = rsp.waitrequest;
  assign avs_readdata    = rsp.readdata;

  // ----------------------------------------------------------------
  // write decode into set and clear strobes and the level write strobe
  // ----------------------------------------------------------------
  logic [LINES-1:0] pu_set;
  logic [LINES-1:0] pu_clr;
  logic [LINES-1:0] b_set;
  logic [LINES-1:0] b_clr;
  logic [LINES-1:0] ow_set;
  logic [LINES-1:0] ow_clr;
  logic             lvl_wr;

  // one-cycle strobes in the completing cycle of a write
  always_comb begin
    pu_set = '0;
    pu_clr = '0;
    b_set  = '0;
    b_clr  = '0;
    ow_set = '0;
    ow_clr = '0;
    lvl_wr = 1'b0;
    if (wr_go) begin
      case (req.address)
        OFS_PULLUP_ON:        pu_set = wmask[LINES-1:0];
        OFS_PULLUP_OFF:       pu_clr = wmask[LINES-1:0];
        OFS_PERIPH_A_ASSIGN:  b_clr  = wmask[LINES-1:0];
        OFS_PERIPH_B_ASSIGN:  b_set  = wmask[LINES-1:0];
        OFS_OUT_WRITE_UNMASK: ow_set = wmask[LINES-1:0];
        OFS_OUT_WRITE_MASK:   ow_clr = wmask[LINES-1:0];
        OFS_OUTPUT_LEVEL_DATA: lvl_wr = 1'b1;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // line state holders
  // ----------------------------------------------------------------
  logic [LINES-1:0] pu_on_r;
  logic [LINES-1:0] b_sel_r;
  logic [LINES-1:0] ow_en_r;
  logic [LINES-1:0] lvl_r;

  iolm_setclr #(.W(LINES), .RSTV(RST_PULLUP_ON[LINES-1:0])) u_pullup (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .set_bits (pu_set),
    .clr_bits (pu_clr),
    .state_r  (pu_on_r)
  );

  iolm_setclr #(.W(LINES), .RSTV(RST_PERIPH_B[LINES-1:0])) u_periph (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .set_bits (b_set),
    .clr_bits (b_clr),
    .state_r  (b_sel_r)
  );

  iolm_setclr #(.W(LINES), .RSTV(RST_WRITE_UNMSK[LINES-1:0])) u_owmask (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .set_bits (ow_set),
    .clr_bits (ow_clr),
    .state_r  (ow_en_r)
  );

  // level register gated by the write mask
  iolm_out_level #(.W(LINES)) u_level (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .wr_en    (lvl_wr),
    .wr_data  (wmask[LINES-1:0] | (lvl_r & ~be_mask[LINES-1:0])),
    .wr_allow (ow_en_r),
    .level_r  (lvl_r)
  );

  // line outputs
  assign pullup_en    = pu_on_r;
  assign periph_b_sel = b_sel_r;
  assign line_level   = lvl_r;

  // ----------------------------------------------------------------
  // read data mux
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;

  // status registers reflect held state, unused bits read zero
  always_comb begin
    rd_mux = IOLM_ZERO;
    case (req.address)
      OFS_PULLUP_STATE:        rd_mux[LINES-1:0] = ~pu_on_r;
      OFS_PERIPH_CHOICE_STATE: rd_mux[LINES-1:0] = b_sel_r;
      OFS_OUT_WRITE_MSTATE:    rd_mux[LINES-1:0] = ow_en_r;
      OFS_OUTPUT_LEVEL_DATA:   rd_mux[LINES-1:0] = lvl_r;
      default:                 rd_mux = IOLM_ZERO;
    endcase
  end

  // read data latched in the wait cycle, shown in the done cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_r <= IOLM_ZERO;
    end else if (rd_go) begin
      rdata_r <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_pullup_on_set: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_go && req.address == OFS_PULLUP_ON) |=> ((pu_on_r & $past(wmask[LINES-1:0])) == $past(wmask[LINES-1:0])))
    else $error("pull-up enable write did not take");

  a_pullup_off_clr: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_go && req.address == OFS_PULLUP_OFF) |=> ((pu_on_r & $past(wmask[LINES-1:0])) == '0))
    else $error("pull-up disable write did not take");

  a_pullup_status_inv: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_go && req.address == OFS_PULLUP_STATE) |=> (avs_readdata[LINES-1:0] == ~$past(pu_on_r)))
    else $error("pull-up status not inverted");

  a_periph_a_assign: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_go && req.address == OFS_PERIPH_A_ASSIGN) |=>
    (b_sel_r == ($past(b_sel_r) & ~$past(wmask[LINES-1:0]))))
    else $error("peripheral a assign wrong");

  a_periph_b_assign: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_go && req.address == OFS_PERIPH_B_ASSIGN) |=>
    (b_sel_r == ($past(b_sel_r) | $past(wmask[LINES-1:0]))))
    else $error("peripheral b assign wrong");

  a_periph_status_rd: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_go && req.address == OFS_PERIPH_CHOICE_STATE) |=> (avs_readdata[LINES-1:0] == $past(b_sel_r)))
    else $error("peripheral status read wrong");

  a_unmask_write: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_go && req.address == OFS_OUT_WRITE_UNMASK) |=>
    (ow_en_r == ($past(ow_en_r) | $past(wmask[LINES-1:0]))))
    else $error("write unmask wrong");

  a_mask_write: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_go && req.address == OFS_OUT_WRITE_MASK) |=>
    (ow_en_r == ($past(ow_en_r) & ~$past(wmask[LINES-1:0]))))
    else $error("write mask wrong");

  a_mask_status_rd: assert property (@(posedge clk_sys) disable iff (rst)
    (rd_go && req.address == OFS_OUT_WRITE_MSTATE) |=> (avs_readdata[LINES-1:0] == $past(ow_en_r)))
    else $error("write mask status read wrong");

  a_level_masked: assert property (@(posedge clk_sys) disable iff (rst)
    (lvl_wr) |=> (((line_level ^ $past(line_level)) & ~$past(ow_en_r)) == '0))
    else $error("masked line changed level");

  a_status_fresh: assert property (@(posedge clk_sys) disable iff (rst)
    (wr_go && req.address == OFS_OUT_WRITE_UNMASK) ##2 (rd_go && req.address == OFS_OUT_WRITE_MSTATE)
    |=> ((avs_readdata[LINES-1:0] & $past(wmask[LINES-1:0], 3)) == $past(wmask[LINES-1:0], 3)))
    else $error("status not fresh after write");

  a_wait_one: assert property (@(posedge clk_sys) disable iff (rst)
    ((req.read || req.write) && state_r == IOLM_IDLE) |=> !avs_waitrequest)
    else $error("waitrequest held too long");

  // a fresh request always sees exactly one stall cycle first
  a_wait_first: assert property (@(posedge clk_sys) disable iff (rst)
    ((req.read || req.write) && state_r == IOLM_IDLE) |-> avs_waitrequest)
    else $error("first request cycle not stalled");

  // read data stands until the next read request is taken
  a_rdata_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !rd_go |=> $stable(avs_readdata))
    else $error("read data changed without a read");

  // held line state moves only on a write to its own set, clear or level data register
  a_pu_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    !(wr_go && (req.address == OFS_PULLUP_ON || req.address == OFS_PULLUP_OFF)) |=> $stable(pu_on_r))
    else $error("pull-up state changed without a write");

  a_periph_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    !(wr_go && (req.address == OFS_PERIPH_A_ASSIGN || req.address == OFS_PERIPH_B_ASSIGN))
    |=> $stable(b_sel_r))
    else $error("peripheral choice changed without a write");

  a_mask_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    !(wr_go && (req.address == OFS_OUT_WRITE_UNMASK || req.address == OFS_OUT_WRITE_MASK))
    |=> $stable(ow_en_r))
    else $error("write mask changed without a write");

  a_level_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    !lvl_wr |=> $stable(line_level))
    else $error("level changed without a level write");

  // unmasked lines in enabled lanes take the written level
  a_level_follow: assert property (@(posedge clk_sys) disable iff (rst)
    lvl_wr |=> ((line_level & $past(ow_en_r & be_mask[LINES-1:0])) == $past(wmask[LINES-1:0] & ow_en_r)))
    else $error("unmasked line missed level write");

  // reset brings every held state to its start value
  a_reset_vals: assert property (@(posedge clk_sys)
    rst |=> (pullup_en == RST_PULLUP_ON[LINES-1:0] && periph_b_sel == RST_PERIPH_B[LINES-1:0]
             && ow_en_r == RST_WRITE_UNMSK[LINES-1:0] && line_level == RST_LEVEL_DATA[LINES-1:0]))
    else $error("reset values wrong");

  c_pullup_off: cover property (@(posedge clk_sys) disable iff (rst)
    wr_go && req.address == OFS_PULLUP_OFF);
  c_periph_b: cover property (@(posedge clk_sys) disable iff (rst)
    wr_go && req.address == OFS_PERIPH_B_ASSIGN);
  c_level_write: cover property (@(posedge clk_sys) disable iff (rst)
    lvl_wr && (ow_en_r != '0));
  c_status_read: cover property (@(posedge clk_sys) disable iff (rst)
    rd_go && req.address == OFS_OUT_WRITE_MSTATE);
  c_read_pair: cover property (@(posedge clk_sys) disable iff (rst)
    rd_go ##3 rd_go);

endmodule

/* File: iolm_pin_model.sv */
module iolm_pin_model
  import iolm_pkg::*;
(
  // clock
  input  wire logic        clk_sys,
  // line controls from the block
  input  wire logic [31:0] pullup_en,
  input  wire logic [31:0] periph_b_sel,
  // pad levels and what each peripheral sees
  output logic      [31:0] pad,
  output logic      [31:0] to_a,
  output logic      [31:0] to_b
);
  timeunit 1ns;
  timeprecision 1ps;

  logic flip_r;

  // ----------------------------------------------------------------
  // pads
  // ----------------------------------------------------------------
  // an unpulled, undriven pad wanders every cycle so no stale level hides
  initial flip_r = 1'b0;
  always @(posedge clk_sys) flip_r <= ~flip_r;

  // pulled lines sit high, the rest follow the wandering pattern
  assign pad  = pullup_en | {32{flip_r}};
  // each pad reaches only the peripheral that owns it
  assign to_a = pad & ~periph_b_sel;
  assign to_b = pad & periph_b_sel;
endmodule

/* File: testbench.sv */
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin bad_count++; $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module testbench
  import iolm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys, rst, avs_read, avs_write, avs_waitrequest;
  logic [5:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, pullup_en, periph_b_sel, line_level, pad, to_a, to_b;
  int          bad_count, checked;

  // ----------------------------------------------------------------
  // clock, design and pad model
  // ----------------------------------------------------------------
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  iolm_top iolm_top_inst (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pullup_en(pullup_en),
    .periph_b_sel(periph_b_sel), .line_level(line_level));

  iolm_pin_model iolm_pin_model_inst (.clk_sys(clk_sys), .pullup_en(pullup_en),
    .periph_b_sel(periph_b_sel), .pad(pad), .to_a(to_a), .to_b(to_b));

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  // one request, held until waitrequest low at a rising edge, then one idle cycle
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    // right after an edge the design's outputs still hold what that edge sampled
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
    logic [31:0] q;
    xfer(1'b1, a, d, be, q);
  endtask

  // read and compare against the expected word
  task automatic rd(input logic [5:0] a, input logic [31:0] ex, input string nm);
    logic [31:0] q;
    xfer(1'b0, a, 32'h00000000, 4'hF, q);
    `CHK(nm, ex, q)
  endtask

  // print counts and verdict, then stop
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 6'h00;
    avs_byteenable = 4'h0; avs_writedata = 32'h00000000; bad_count = 0; checked = 0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    `CHK("pullup_en", 32'hFFFFFFFF, pullup_en)
    `CHK("periph_b_sel", 32'h00000000, periph_b_sel)
    `CHK("line_level", 32'h00000000, line_level)
    rd(OFS_PULLUP_STATE, 32'h00000000, "pullup_state");
    rd(OFS_PERIPH_CHOICE_STATE, 32'h00000000, "periph_choice_state");
    rd(OFS_OUT_WRITE_MSTATE, 32'h00000000, "out_write_mask_state");
    $display("test reset done");

    wr(OFS_PULLUP_OFF, 32'h000000F0);
    rd(OFS_PULLUP_STATE, 32'h000000F0, "pullup_state off");
    wr(OFS_PULLUP_ON, 32'h00000030);
    rd(OFS_PULLUP_STATE, 32'h000000C0, "pullup_state on");
    wr(OFS_PULLUP_OFF, 32'hFFFFFFFF, 4'h2);
    rd(OFS_PULLUP_STATE, 32'h0000FFC0, "pullup_state lane");
    `CHK("pullup_en", 32'hFFFF003F, pullup_en)
    $display("test pullup done");

    wr(OFS_PERIPH_B_ASSIGN, 32'hA5A50000);
    rd(OFS_PERIPH_CHOICE_STATE, 32'hA5A50000, "choice b");
    wr(OFS_PERIPH_A_ASSIGN, 32'h80000001);
    rd(OFS_PERIPH_CHOICE_STATE, 32'h25A50000, "choice a");
    `CHK("periph_b_sel", 32'h25A50000, periph_b_sel)
    `CHK("to_b pulled", 32'h25A50000, to_b & pullup_en)
    `CHK("to_a pulled", 32'hDA5A003F & 32'hFFFF003F, to_a & pullup_en)
    $display("test periph done");

    wr(OFS_OUTPUT_LEVEL_DATA, 32'hFFFFFFFF);
    `CHK("line_level masked", 32'h00000000, line_level)
    wr(OFS_OUT_WRITE_UNMASK, 32'h0000FF00);
    rd(OFS_OUT_WRITE_MSTATE, 32'h0000FF00, "mask_state unmask");
    wr(OFS_OUTPUT_LEVEL_DATA, 32'hFFFFFFFF);
    `CHK("line_level high", 32'h0000FF00, line_level)
    rd(OFS_OUTPUT_LEVEL_DATA, 32'h0000FF00, "level read");
    wr(OFS_OUT_WRITE_MASK, 32'h00000F00);
    rd(OFS_OUT_WRITE_MSTATE, 32'h0000F000, "mask_state mask");
    wr(OFS_OUTPUT_LEVEL_DATA, 32'h00000000);
    `CHK("line_level low", 32'h00000F00, line_level)
    $display("test write mask done");

    rd(6'h3C, 32'h00000000, "unmapped");
    rd(OFS_PERIPH_A_ASSIGN, 32'h00000000, "write only");
    wr(OFS_PULLUP_STATE, 32'h00000000);
    rd(OFS_PULLUP_STATE, 32'h0000FFC0, "status ro");
    $display("test refused done");
    complete_run();
  end
endmodule
